// file: core/pwc_channel.sv
// 12-bit PWM channel with dead time, fault filter and AHB-Lite register slave.
// Assumes one clock serving as oscillator and CPU clock; fault input synchronous to it.
//
// Functional notes
// - Period is 12 bits: low byte plus high nibble; high bits 7-4 read zero.
// - Period high then low; low write arms update taken at next overflow.
// - Period equals 12-bit value times one prescaled channel clock.
// - Period bytes read back at any time in any order.
// - Duty uses same high-then-low discipline, applied from next period.
// - Active duty interval equals 12-bit duty value times channel clock.
// - 8-bit dead time, reset zero, counted in undivided clock cycles.
// - Filter clock select: CPU clock divided by 1, 4, 16 or 64.
// - 6-bit filter count of stable sampling clocks sets the debounce time.
// - Debounce delay lies between count minus one and count sample clocks.
// - Overflow sets interrupt flag; enable gates request; software writes zero to clear.
// - Fault shutdown sets fault status; software clears it to resume.
// - Fault polarity: 0 low level shuts off, 1 high level shuts off.
// - Output polarity select: 00 both high, 01, 10 mixed, 11 both low.
// - Channel clock is oscillator divided by 2, 4, 8 or 16.
// - Second channel: low byte write needed, deferred to next period, free reads; this module builds no second channel.
// - Second channel period equals its 12-bit value times its clock; there is only one channel here.
// - Fault level field picks forced levels of primary and complementary outputs.
// - Each output drives its pin only while its enable bit is set.
//
// Implementation choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

module pwc_channel
	import pwc_pkg::*;
#(
	parameter int PERIOD_BITS = 12,
	parameter int DEAD_BITS   = 8
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Fault sensing
	input  wire logic        faultInput,
	// Switch outputs, enables low while driving
	output logic             primaryOutput,
	output logic             primaryOutputOe_n,
	output logic             complementaryOutput,
	output logic             complementaryOutputOe_n,
	// Overflow interrupt request
	output logic             irqRequest
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (PERIOD_BITS != 12) begin : g_badPeriod
		$error("PERIOD_BITS must be 12");
	end
	if (DEAD_BITS != 8) begin : g_badDead
		$error("DEAD_BITS must be 8");
	end

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	// Join high nibble and low byte into a 12-bit value
	function automatic logic [11:0] join12(input logic [3:0] hi, input logic [7:0] lo);
		join12 = {hi, lo};
	endfunction : join12

	// ----------------------------------------------------------------
	// Reset synchroniser
	// ----------------------------------------------------------------
	logic rstMeta;
	logic rstSync;

	// Release reset through two flops
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rstMeta <= 1'b0;
			rstSync <= 1'b0;
		end else begin
			rstMeta <= 1'b1;
			rstSync <= rstMeta;
		end
	end

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic       irqEnable;
	logic       irqFlag;
	logic       faultStatus;
	logic       faultPolarity;
	logic [1:0] outputPolaritySelect;
	logic [1:0] channelPrescaleSelect;
	logic [7:0] periodLow;
	logic [3:0] periodHigh;
	logic [7:0] dutyLow;
	logic [3:0] dutyHigh;
	logic [7:0] deadTime;
	logic [1:0] filterClockSelect;
	logic [5:0] filterCount;
	logic [1:0] faultOutputLevels;
	logic       primaryOutputEnable;
	logic       complementaryOutputEnable;
	logic       faultDetectEnable;
	logic       periodPending;
	logic       dutyPending;
	logic [11:0] periodActive;
	logic [11:0] dutyActive;
	logic [11:0] periodStaged;
	logic [11:0] dutyStaged;
	logic [11:0] count;

	// ----------------------------------------------------------------
	// AHB-Lite address and data phase
	// ----------------------------------------------------------------
	logic       dataWrite;
	logic [7:0] dataAddr;
	logic       addrValid;
	logic       wrStrobe;

	assign addrValid = hsel && htrans[1] && hready;
	assign wrStrobe  = dataWrite;

	// Capture the address phase of a write
	always_ff @(posedge clk or negedge rstSync) begin
		if (!rstSync) begin
			dataWrite <= 1'b0;
			dataAddr  <= 8'h00;
		end else begin
			dataWrite <= addrValid && hwrite;
			dataAddr  <= haddr[7:0];
		end
	end

	// Zero wait state, always OKAY
	always_ff @(posedge clk or negedge rstSync) begin
		if (!rstSync) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// Read data muxed in the address phase, held for the data phase
	logic [7:0] next_readByte;
	always_comb begin
		next_readByte = 8'h00;
		case (haddr[7:0])
			`PWC_OFS_CONTROL:      next_readByte = {irqEnable, irqFlag, faultStatus, faultPolarity,
			                                        outputPolaritySelect, channelPrescaleSelect};
			`PWC_OFS_PERIOD_LOW:   next_readByte = periodLow;
			`PWC_OFS_PERIOD_HIGH:  next_readByte = {4'h0, periodHigh};
			`PWC_OFS_DUTY_LOW:     next_readByte = dutyLow;
			`PWC_OFS_DUTY_HIGH:    next_readByte = {4'h0, dutyHigh};
			`PWC_OFS_DEAD_TIME:    next_readByte = deadTime;
			`PWC_OFS_FAULT_FILTER: next_readByte = {filterClockSelect, filterCount};
			`PWC_OFS_OUTPUT_CFG:   next_readByte = {3'h0, faultDetectEnable, complementaryOutputEnable,
			                                        primaryOutputEnable, faultOutputLevels};
			`PWC_OFS_COUNTER:      next_readByte = count[7:0];
			default:               next_readByte = 8'h00;
		endcase
	end

	// Read data register
	always_ff @(posedge clk or negedge rstSync) begin
		if (!rstSync) begin
			hrdata <= 32'h0000_0000;
		end else if (addrValid && !hwrite) begin
			if (haddr[7:0] == `PWC_OFS_COUNTER) begin
				hrdata <= {20'h00000, count};
			end else begin
				hrdata <= {24'h000000, next_readByte};
			end
		end
	end

	// ----------------------------------------------------------------
	// Channel clock prescaler
	// ----------------------------------------------------------------
	logic [3:0] preDiv;
	logic       chanTick;

	// Free running divider of the oscillator clock
	always_ff @(posedge clk or negedge rstSync) begin
		if (!rstSync) begin
			preDiv <= 4'h0;
		end else begin
			preDiv <= preDiv + 4'h1;
		end
	end

	// Tick once per 2, 4, 8 or 16 clocks
	always_comb begin
		case (channelPrescaleSelect)
			2'b00:   chanTick = (preDiv[0]   == 1'b1);
			2'b01:   chanTick = (preDiv[1:0] == 2'h3);
			2'b10:   chanTick = (preDiv[2:0] == 3'h7);
			default: chanTick = (preDiv      == 4'hf);
		endcase
	end

	// ----------------------------------------------------------------
	// Period counter
	// ----------------------------------------------------------------
	logic overflow;

	// Last tick of a period, zero period overflows every tick
	assign overflow = chanTick && ({1'b0, count} + 13'h0001 >= {1'b0, periodActive});

	// Count channel clocks from zero up to the period minus one
	always_ff @(posedge clk or negedge rstSync) begin
		if (!rstSync) begin
			count <= 12'h000;
		end else if (overflow) begin
			count <= 12'h000;
		end else if (chanTick) begin
			count <= count + 12'h001;
		end
	end

	// ----------------------------------------------------------------
	// Staged registers and update at overflow
	// ----------------------------------------------------------------
	// Software side period and duty bytes
	always_ff @(posedge clk or negedge rstSync) begin
		if (!rstSync) begin
			periodLow  <= `PWC_RST_BYTE;
			periodHigh <= `PWC_RST_NIBBLE;
			dutyLow    <= `PWC_RST_BYTE;
			dutyHigh   <= `PWC_RST_NIBBLE;
		end else if (wrStrobe) begin
			case (dataAddr)
				`PWC_OFS_PERIOD_LOW:  periodLow  <= hwdata[7:0];
				`PWC_OFS_PERIOD_HIGH: periodHigh <= hwdata[3:0];
				`PWC_OFS_DUTY_LOW:    dutyLow    <= hwdata[7:0];
				`PWC_OFS_DUTY_HIGH:   dutyHigh   <= hwdata[3:0];
				default:              ;
			endcase
		end
	end

	// Low byte write arms the transfer and snapshots both halves, overflow consumes it;
	// a later high-only write waits for the next low write
	always_ff @(posedge clk or negedge rstSync) begin
		if (!rstSync) begin
			periodPending <= 1'b0;
			periodStaged  <= 12'h000;
		end else if (wrStrobe && dataAddr == `PWC_OFS_PERIOD_LOW) begin
			periodPending <= 1'b1;
			periodStaged  <= join12(periodHigh, hwdata[7:0]);
		end else if (overflow) begin
			periodPending <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rstSync) begin
		if (!rstSync) begin
			dutyPending <= 1'b0;
			dutyStaged  <= 12'h000;
		end else if (wrStrobe && dataAddr == `PWC_OFS_DUTY_LOW) begin
			dutyPending <= 1'b1;
			dutyStaged  <= join12(dutyHigh, hwdata[7:0]);
		end else if (overflow) begin
			dutyPending <= 1'b0;
		end
	end

	// Working period and duty, changed only at a boundary
	always_ff @(posedge clk or negedge rstSync) begin
		if (!rstSync) begin
			periodActive <= 12'h000;
			dutyActive   <= 12'h000;
		end else if (overflow) begin
			if (periodPending) begin
				periodActive <= periodStaged;
			end
			if (dutyPending) begin
				dutyActive <= dutyStaged;
			end
		end
	end

	// ----------------------------------------------------------------
	// Control, dead time, filter and output configuration
	// ----------------------------------------------------------------
	// Plain control fields
	always_ff @(posedge clk or negedge rstSync) begin
		if (!rstSync) begin
			irqEnable             <= 1'b0;
			faultPolarity         <= 1'b0;
			outputPolaritySelect  <= 2'b00;
			channelPrescaleSelect <= 2'b00;
			deadTime              <= `PWC_RST_BYTE;
			filterClockSelect     <= 2'b00;
			filterCount           <= 6'h00;
			faultOutputLevels     <= 2'b00;
			primaryOutputEnable   <= 1'b0;
			complementaryOutputEnable <= 1'b0;
			faultDetectEnable     <= 1'b0;
		end else if (wrStrobe) begin
			case (dataAddr)
				`PWC_OFS_CONTROL: begin
					irqEnable             <= hwdata[`PWC_CTL_IRQ_EN];
					faultPolarity         <= hwdata[`PWC_CTL_FAULT_POL];
					outputPolaritySelect  <= hwdata[`PWC_CTL_OPOL_HI:`PWC_CTL_OPOL_LO];
					channelPrescaleSelect <= hwdata[`PWC_CTL_PRE_HI:`PWC_CTL_PRE_LO];
				end
				`PWC_OFS_DEAD_TIME: begin
					deadTime <= hwdata[7:0];
				end
				`PWC_OFS_FAULT_FILTER: begin
					filterClockSelect <= hwdata[`PWC_FLT_CLK_HI:`PWC_FLT_CLK_LO];
					filterCount       <= hwdata[`PWC_FLT_CNT_HI:`PWC_FLT_CNT_LO];
				end
				`PWC_OFS_OUTPUT_CFG: begin
					faultOutputLevels         <= hwdata[`PWC_OCF_LVL_PRI:`PWC_OCF_LVL_CMP];
					primaryOutputEnable       <= hwdata[`PWC_OCF_EN_PRI];
					complementaryOutputEnable <= hwdata[`PWC_OCF_EN_CMP];
					faultDetectEnable         <= hwdata[`PWC_OCF_FAULT_EN];
				end
				default: ;
			endcase
		end
	end

	// Overflow flag, set wins over a zero write
	always_ff @(posedge clk or negedge rstSync) begin
		if (!rstSync) begin
			irqFlag <= 1'b0;
		end else if (overflow) begin
			irqFlag <= 1'b1;
		end else if (wrStrobe && dataAddr == `PWC_OFS_CONTROL && !hwdata[`PWC_CTL_IRQ_FLAG]) begin
			irqFlag <= 1'b0;
		end
	end

	// Interrupt request gated by enable
	always_ff @(posedge clk or negedge rstSync) begin
		if (!rstSync) begin
			irqRequest <= 1'b0;
		end else begin
			irqRequest <= irqFlag && irqEnable;
		end
	end

	// ----------------------------------------------------------------
	// Fault debounce filter
	// ----------------------------------------------------------------
	logic [5:0]     sampleDiv;
	logic           sampleTick;
	logic [5:0]     stableCount;
	logic           faultLevel;
	logic           faultTrip;
	pwc_flt_state_e fltState;

	// Shut-off level depends on polarity bit
	assign faultLevel = faultDetectEnable && (faultInput == faultPolarity);

	// Sampling clock divider of the CPU clock
	always_ff @(posedge clk or negedge rstSync) begin
		if (!rstSync) begin
			sampleDiv <= 6'h00;
		end else begin
			sampleDiv <= sampleDiv + 6'h01;
		end
	end

	// Sample once per 1, 4, 16 or 64 clocks
	always_comb begin
		case (filterClockSelect)
			2'b00:   sampleTick = 1'b1;
			2'b01:   sampleTick = (sampleDiv[1:0] == 2'h3);
			2'b10:   sampleTick = (sampleDiv[3:0] == 4'hf);
			default: sampleTick = (sampleDiv == 6'h3f);
		endcase
	end

	// Free divider phase makes the delay count-1 to count samples
	always_ff @(posedge clk or negedge rstSync) begin
		if (!rstSync) begin
			fltState    <= PWC_FLT_CLEAR;
			stableCount <= 6'h00;
		end else begin
			case (fltState)
				PWC_FLT_CLEAR: begin
					stableCount <= 6'h00;
					if (faultLevel) begin
						fltState <= (filterCount == 6'h00) ? PWC_FLT_TRIPPED : PWC_FLT_COUNT;
					end
				end
				PWC_FLT_COUNT: begin
					if (!faultLevel) begin
						fltState <= PWC_FLT_CLEAR;
					end else if (sampleTick) begin
						if (stableCount + 6'h01 >= filterCount) begin
							fltState <= PWC_FLT_TRIPPED;
						end
						stableCount <= stableCount + 6'h01;
					end
				end
				PWC_FLT_TRIPPED: begin
					if (!faultLevel) begin
						fltState <= PWC_FLT_CLEAR;
					end
				end
				default: fltState <= PWC_FLT_CLEAR;
			endcase
		end
	end

	assign faultTrip = (fltState == PWC_FLT_TRIPPED);

	// Fault status, set by debounced fault, held against clears while tripped
	always_ff @(posedge clk or negedge rstSync) begin
		if (!rstSync) begin
			faultStatus <= 1'b0;
		end else if (faultTrip) begin
			faultStatus <= 1'b1;
		end else if (wrStrobe && dataAddr == `PWC_OFS_CONTROL && !hwdata[`PWC_CTL_FAULT_STAT]) begin
			faultStatus <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Dead time insertion
	// ----------------------------------------------------------------
	logic       rawActive;
	logic       rawPrev;
	logic [7:0] deadCount;
	logic       deadDone;

	assign rawActive = (count < dutyActive);
	assign deadDone  = (deadCount >= deadTime);

	// Restart undivided-clock count at each edge of the raw wave
	always_ff @(posedge clk or negedge rstSync) begin
		if (!rstSync) begin
			rawPrev   <= 1'b0;
			deadCount <= 8'h00;
		end else begin
			rawPrev <= rawActive;
			if (rawActive != rawPrev) begin
				deadCount <= 8'h00;
			end else if (!deadDone) begin
				deadCount <= deadCount + 8'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// Output stage
	// ----------------------------------------------------------------
	logic primaryValid;
	logic complementaryValid;

	// Both sides wait out the dead time after a transition
	assign primaryValid       = rawActive && rawActive == rawPrev && deadDone;
	assign complementaryValid = !rawActive && rawActive == rawPrev && deadDone;

	// Polarity, fault forcing and pin enables
	always_ff @(posedge clk or negedge rstSync) begin
		if (!rstSync) begin
			primaryOutput           <= 1'b0;
			complementaryOutput     <= 1'b0;
			primaryOutputOe_n       <= 1'b1;
			complementaryOutputOe_n <= 1'b1;
		end else begin
			if (faultStatus || faultTrip) begin
				primaryOutput       <= faultOutputLevels[`PWC_OCF_LVL_PRI];
				complementaryOutput <= faultOutputLevels[`PWC_OCF_LVL_CMP];
			end else begin
				primaryOutput       <= primaryValid ^ outputPolaritySelect[1];
				complementaryOutput <= complementaryValid ^ outputPolaritySelect[0];
			end
			primaryOutputOe_n       <= !primaryOutputEnable;
			complementaryOutputOe_n <= !complementaryOutputEnable;
		end
	end

	// Transfer size is ignored; byte writes land in the low lane
	logic unusedBits;
	assign unusedBits = ^{hsize, haddr[31:8], hwdata[31:8]};

endmodule : pwc_channel

`default_nettype wire

// file: shared/pwc_defs.svh
// Register offsets, field positions, reset values and bus widths of the PWM channel.
// Assumes inclusion by bare name from the package, the checker and the testbench.
`ifndef PWC_DEFS_SVH
`define PWC_DEFS_SVH

// Register byte offsets (one aligned word each)
`define PWC_OFS_CONTROL      8'h00
`define PWC_OFS_PERIOD_LOW   8'h04
`define PWC_OFS_PERIOD_HIGH  8'h08
`define PWC_OFS_DUTY_LOW     8'h0c
`define PWC_OFS_DUTY_HIGH    8'h10
`define PWC_OFS_DEAD_TIME    8'h14
`define PWC_OFS_FAULT_FILTER 8'h18
`define PWC_OFS_OUTPUT_CFG   8'h1c
`define PWC_OFS_COUNTER      8'h20

// Control register fields
`define PWC_CTL_IRQ_EN       7
`define PWC_CTL_IRQ_FLAG     6
`define PWC_CTL_FAULT_STAT   5
`define PWC_CTL_FAULT_POL    4
`define PWC_CTL_OPOL_HI      3
`define PWC_CTL_OPOL_LO      2
`define PWC_CTL_PRE_HI       1
`define PWC_CTL_PRE_LO       0

// Fault filter register fields
`define PWC_FLT_CLK_HI       7
`define PWC_FLT_CLK_LO       6
`define PWC_FLT_CNT_HI       5
`define PWC_FLT_CNT_LO       0

// Output configuration register fields
`define PWC_OCF_LVL_PRI      1
`define PWC_OCF_LVL_CMP      0
`define PWC_OCF_EN_PRI       2
`define PWC_OCF_EN_CMP       3
`define PWC_OCF_FAULT_EN     4

// Reset values
`define PWC_RST_BYTE         8'h00
`define PWC_RST_NIBBLE       4'h0

// Bus widths
`define PWC_ADDR_DEC_BITS    8

`endif

// file: shared/pwc_pkg.sv
// Types of the PWM channel.
// Assumes pwc_defs.svh is on the include path.
`include "pwc_defs.svh"

package pwc_pkg;

	// Fault debounce filter state
	typedef enum logic [1:0] {
		PWC_FLT_CLEAR   = 2'b00,
		PWC_FLT_COUNT   = 2'b01,
		PWC_FLT_TRIPPED = 2'b10
	} pwc_flt_state_e;

	typedef logic [7:0] pwc_byte_t;

endpackage : pwc_pkg

// file: tb/pwc_channel_asserts.sv
// Checker for the PWM channel ports, bound to the channel module.
// Assumes one clock, zero-wait AHB-Lite and byte data in hwdata[7:0].
`timescale 1ns/10ps
`default_nettype none
`include "pwc_defs.svh"

module pwc_channel_asserts (
	// Clock and reset
	input wire logic        clk,
	input wire logic        resetn,
	// Bus
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// Pins
	input wire logic        faultInput,
	input wire logic        primaryOutput,
	input wire logic        primaryOutputOe_n,
	input wire logic        complementaryOutput,
	input wire logic        complementaryOutputOe_n,
	input wire logic        irqRequest
);
	logic       dPh;
	logic       dWr;
	logic [7:0] dAdr;
	logic [7:0] ctl;
	logic [7:0] flt;
	logic [4:0] cfg;

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	// Data phase tracking
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			dPh <= 1'b0;
			dWr <= 1'b0;
			dAdr <= 8'h00;
		end else if (hready) begin
			dPh <= hsel && htrans[1];
			dWr <= hwrite;
			dAdr <= haddr[7:0];
		end
	end

	// Shadow of software-written fields
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctl <= 8'h00;
			flt <= 8'h00;
			cfg <= 5'h00;
		end else if (dPh && dWr && hready) begin
			case (dAdr)
				`PWC_OFS_CONTROL: ctl <= hwdata[7:0];
				`PWC_OFS_FAULT_FILTER: flt <= hwdata[7:0];
				`PWC_OFS_OUTPUT_CFG: cfg <= hwdata[4:0];
				default: ;
			endcase
		end
	end

	// --------------------------------------------------------------
	// Assertions
	// --------------------------------------------------------------
	sequence sFaultHeld;
		cfg[4] && flt == 8'h00 && faultInput == ctl[4];
	endsequence

	a_resp_okay: assert property (!hresp)
		else $error("error response");
	a_ready_high: assert property (hreadyout)
		else $error("wait state inserted");
	a_reserved_zero: assert property (dPh && !dWr &&
		(dAdr == `PWC_OFS_PERIOD_HIGH || dAdr == `PWC_OFS_DUTY_HIGH) |-> hrdata[31:4] == 28'h0)
		else $error("reserved bits read nonzero");
	a_unmapped_zero: assert property (dPh && !dWr && dAdr > `PWC_OFS_COUNTER |-> hrdata == 32'h0)
		else $error("unmapped read nonzero");
	a_pin_enable: assert property ({primaryOutputOe_n, complementaryOutputOe_n} == ~$past({cfg[2], cfg[3]}))
		else $error("output enable mismatch");
	a_irq_gate: assert property (irqRequest |-> $past(ctl[7]))
		else $error("request without enable");
	a_dead_gap: assert property (!cfg[4] && ctl[3:2] == $past(ctl[3:2], 2)
		|-> !((primaryOutput ^ ctl[3]) && (complementaryOutput ^ ctl[2])))
		else $error("both outputs active");
	a_fault_levels: assert property (sFaultHeld [*8]
		|-> primaryOutput == cfg[1] && complementaryOutput == cfg[0])
		else $error("fault levels not forced");
endmodule : pwc_channel_asserts

bind pwc_channel pwc_channel_asserts u_asserts (
	.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.faultInput(faultInput), .primaryOutput(primaryOutput), .primaryOutputOe_n(primaryOutputOe_n),
	.complementaryOutput(complementaryOutput), .complementaryOutputOe_n(complementaryOutputOe_n),
	.irqRequest(irqRequest)
);
`default_nettype wire

// file: tb/pwc_switch_model.sv
// Switch and fault sensor model: drives the fault line, times the primary pin.
// Assumes the primary pin is sampled on clk.
`timescale 1ns/10ps
`default_nettype none

module pwc_switch_model (
	// Clock and command
	input  wire logic        clk,
	input  wire logic        faultOn,
	input  wire logic        faultPol,
	// Pins
	input  wire logic        primaryOutput,
	output logic             faultInput,
	// Pulse times in clk cycles
	output logic      [15:0] highTime,
	output logic      [15:0] periodTime
);
	logic [15:0] hiCnt;
	logic [15:0] perCnt;
	logic        prev;

	// Sensor level, fault shown at the selected polarity
	assign faultInput = faultOn ? faultPol : !faultPol;

	// Rise to rise span and high width
	always_ff @(posedge clk) begin
		prev <= primaryOutput;
		perCnt <= (primaryOutput && !prev) ? 16'h0001 : perCnt + 16'h0001;
		hiCnt <= !primaryOutput ? hiCnt : (!prev ? 16'h0001 : hiCnt + 16'h0001);
		if (primaryOutput && !prev) begin
			periodTime <= perCnt;
		end
		if (!primaryOutput && prev) begin
			highTime <= hiCnt;
		end
	end
endmodule : pwc_switch_model
`default_nettype wire

// file: tb/pwm_channel_12bit_fault_tb_top.sv
// Testbench of the PWM channel: bus tasks, pulse timing and fault handling.
// Assumes a 200 MHz clock and a zero-wait AHB-Lite slave.
`timescale 1ns/10ps
`default_nettype none
`include "pwc_defs.svh"

module pwm_channel_12bit_fault_tb_top import pwc_pkg::*;;
	logic        clk, resetn, hsel, hwrite, hready, hresp, irq;
	logic        faultIn, faultOn, faultPol, priOut, cmpOut, priOe_n, cmpOe_n;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata;
	logic [15:0] highTime, periodTime;
	int          numErrors = 0, comparisons = 0;

	pwc_channel DUT (
		.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
		.hresp(hresp), .faultInput(faultIn), .primaryOutput(priOut), .primaryOutputOe_n(priOe_n),
		.complementaryOutput(cmpOut), .complementaryOutputOe_n(cmpOe_n), .irqRequest(irq)
	);
	pwc_switch_model u_model (
		.clk(clk), .faultOn(faultOn), .faultPol(faultPol), .primaryOutput(priOut),
		.faultInput(faultIn), .highTime(highTime), .periodTime(periodTime)
	);

	// --------------------------------------------------------------
	// Tasks
	// --------------------------------------------------------------
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", comparisons, numErrors);
		if (numErrors == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : stop_test

	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			numErrors++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : cmp

	// One single transfer, entered just after a rising edge
	task automatic busAcc(input logic wr, input logic [7:0] a, input pwc_byte_t d, output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= wr;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h0, d};
		do @(posedge clk); while (hready !== 1'b1);
		q = hrdata;
	endtask : busAcc

	task automatic wr(input logic [7:0] a, input pwc_byte_t d);
		logic [31:0] q;
		busAcc(1'b1, a, d, q);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
		logic [31:0] q;
		busAcc(1'b0, a, 8'h00, q);
		cmp(q & m, e);
	endtask : rd

	// Waits three periods, then checks the measured times
	task automatic pulse(input int per, input int hi);
		repeat (3 * per + 20) @(posedge clk);
		cmp(32'(periodTime), per);
		cmp(32'(highTime), hi);
	endtask : pulse

	// Clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Watchdog
	initial begin
		repeat (40000) @(posedge clk);
		numErrors++;
		stop_test();
	end

	// Main sequence
	initial begin
		hsel = 1'b0;
		hwrite = 1'b0;
		htrans = 2'b00;
		hsize = 3'h2;
		haddr = 32'h0;
		hwdata = 32'h0;
		faultOn = 1'b0;
		faultPol = 1'b1;
		resetn = 1'b0;
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		// Reset values, reserved bits, unmapped space
		for (int i = 1; i < 8; i++) begin
			rd(8'(i * 4), 32'h0);
		end
		rd(`PWC_OFS_CONTROL, 32'h40);
		wr(`PWC_OFS_PERIOD_HIGH, 8'hff);
		rd(`PWC_OFS_PERIOD_HIGH, 32'h0f);
		wr(8'h24, 8'h5a);
		rd(8'h24, 32'h0);
		// Period 16 ticks, duty 4 ticks, prescale and dead time table
		wr(`PWC_OFS_DUTY_LOW, 8'h04);
		wr(`PWC_OFS_PERIOD_HIGH, 8'h00);
		wr(`PWC_OFS_PERIOD_LOW, 8'h10);
		wr(`PWC_OFS_OUTPUT_CFG, 8'h0c);
		for (int k = 0; k < 4; k++) begin
			wr(`PWC_OFS_CONTROL, 8'(k));
			wr(`PWC_OFS_DEAD_TIME, 8'(k));
			pulse(32 << k, (8 << k) - k - 1);
		end
		cmp(32'({priOe_n, cmpOe_n}), 32'h0);
		// Output polarity codes
		for (int p = 0; p < 4; p++) begin
			wr(`PWC_OFS_CONTROL, 8'(p << 2));
			pulse(32, p[1] ? 28 : 4);
		end
		// Staged period and duty updates
		wr(`PWC_OFS_CONTROL, 8'h00);
		wr(`PWC_OFS_PERIOD_HIGH, 8'h01);
		pulse(32, 4);
		wr(`PWC_OFS_PERIOD_LOW, 8'h10);
		wr(`PWC_OFS_PERIOD_HIGH, 8'h02);
		pulse(544, 4);
		wr(`PWC_OFS_DUTY_HIGH, 8'h01);
		pulse(544, 4);
		wr(`PWC_OFS_DUTY_LOW, 8'h00);
		pulse(544, 508);
		rd(`PWC_OFS_PERIOD_LOW, 32'h10);
		rd(`PWC_OFS_PERIOD_HIGH, 32'h02);
		// Overflow request, then clear by writing zero
		wr(`PWC_OFS_CONTROL, 8'h80);
		repeat (600) @(posedge clk);
		cmp(32'(irq), 32'h1);
		// Clear just after a period start, far from the next overflow
		@(posedge priOut);
		@(posedge clk);
		wr(`PWC_OFS_CONTROL, 8'h80);
		repeat (3) @(posedge clk);
		cmp(32'(irq), 32'h0);
		rd(`PWC_OFS_CONTROL, 32'h80);
		// Fault: filtered high-active, then unfiltered low-active
		for (int i = 0; i < 2; i++) begin
			wr(`PWC_OFS_OUTPUT_CFG, 8'h0e);
			faultPol <= !i[0];
			wr(`PWC_OFS_CONTROL, 8'({!i[0], 4'h0}));
			wr(`PWC_OFS_FAULT_FILTER, i ? 8'h00 : 8'h45);
			wr(`PWC_OFS_OUTPUT_CFG, 8'h1e);
			faultOn <= 1'b1;
			if (i == 0) begin
				repeat (12) @(posedge clk);
				rd(`PWC_OFS_CONTROL, 32'h0, 32'h20);
			end
			repeat (60) @(posedge clk);
			cmp(32'({priOut, cmpOut}), 32'h2);
			rd(`PWC_OFS_CONTROL, 32'h20, 32'h20);
			faultOn <= 1'b0;
			repeat (60) @(posedge clk);
			wr(`PWC_OFS_CONTROL, 8'({!i[0], 4'h0}));
			rd(`PWC_OFS_CONTROL, 32'h0, 32'h20);
			pulse(544, 508);
		end
		stop_test();
	end
endmodule : pwm_channel_12bit_fault_tb_top
`default_nettype wire
